// >>> rfd_defines.vh
// Constants of the 16-bit instruction format decoder.
// Assumes one core clock; included by rfd_decoder.v and rfd_opmap.v.
`ifndef RFD_DEFINES_VH
`define RFD_DEFINES_VH

// ****************************************
// Widths
// ****************************************
`define RFD_IW 16
`define RFD_AW 32

// ****************************************
// Format codes
// ****************************************
`define RFD_F_ZERO 4'h0
`define RFD_F_N 4'h1
`define RFD_F_M 4'h2
`define RFD_F_NM 4'h3
`define RFD_F_MD 4'h4
`define RFD_F_ND4 4'h5
`define RFD_F_NMD 4'h6
`define RFD_F_D 4'h7
`define RFD_F_D12 4'h8
`define RFD_F_ND8 4'h9
`define RFD_F_I 4'ha
`define RFD_F_NI 4'hb

// ****************************************
// Operand addressing modes
// ****************************************
`define RFD_A_NONE 4'h0
`define RFD_A_DIRECT 4'h1
`define RFD_A_IND 4'h2
`define RFD_A_POSTINC 4'h3
`define RFD_A_PREDEC 4'h4
`define RFD_A_INDEXED 4'h5
`define RFD_A_BASEDISP 4'h6
`define RFD_A_PCREL 4'h7
`define RFD_A_GBRDISP 4'h8
`define RFD_A_GBRINDEX 4'h9
`define RFD_A_CTRLREG 4'ha
`define RFD_A_ACCUM 4'hb
`define RFD_A_IMM 4'hc

// ****************************************
// Immediate extension kinds
// ****************************************
`define RFD_X_ZERO 2'h0
`define RFD_X_SIGN 2'h1
`define RFD_X_TRAP 2'h2

// ****************************************
// Reset values
// ****************************************
`define RFD_RST_WORD 32'h0000_0000
`define RFD_RST_IDX 4'h0

`endif

// >>> rfd_opmap.v
// Opcode class map: turns opcode bits into format and operand modes.
// Assumes a purely combinational use by rfd_decoder.
`timescale 1ns/100ps
`include "rfd_defines.vh"
module rfd_opmap
(
   // Instruction word
   input wire [15:0] instr,
   // Classification
   output reg [3:0] fmt,
   output reg [3:0] src_mode,
   output reg [3:0] dst_mode,
   output reg [1:0] imm_ext
);

// ****************************************
// Class decode
// ****************************************
// Same field layout means different operands per opcode, so the
// top nibble and the tail nibble (bits 11..8 under 8 and c) pick the meaning together
always @*
begin
   fmt = `RFD_F_ZERO;
   src_mode = `RFD_A_NONE;
   dst_mode = `RFD_A_NONE;
   imm_ext = `RFD_X_ZERO;
   case (instr[15:12])
      4'h0:
      begin
         case (instr[3:0])
            4'h2, 4'ha:
            begin
               fmt = `RFD_F_N;
               src_mode = `RFD_A_CTRLREG;
               dst_mode = `RFD_A_DIRECT;
            end
            4'h3:
            begin
               fmt = `RFD_F_M;
               src_mode = `RFD_A_PCREL;
            end
            4'h4, 4'h5, 4'h6:
            begin
               fmt = `RFD_F_NM;
               src_mode = `RFD_A_DIRECT;
               dst_mode = `RFD_A_INDEXED;
            end
            4'hc, 4'hd, 4'he:
            begin
               fmt = `RFD_F_NM;
               src_mode = `RFD_A_INDEXED;
               dst_mode = `RFD_A_DIRECT;
            end
            4'h7:
            begin
               fmt = `RFD_F_NM;
               src_mode = `RFD_A_DIRECT;
               dst_mode = `RFD_A_DIRECT;
            end
            4'hf:
            begin
               fmt = `RFD_F_NM;
               src_mode = `RFD_A_POSTINC;
               dst_mode = `RFD_A_ACCUM;
            end
            default:
               fmt = `RFD_F_ZERO;
         endcase
      end
      4'h1:
      begin
         fmt = `RFD_F_NMD;
         src_mode = `RFD_A_DIRECT;
         dst_mode = `RFD_A_BASEDISP;
      end
      4'h2, 4'h3, 4'h6:
      begin
         fmt = `RFD_F_NM;
         src_mode = `RFD_A_DIRECT;
         dst_mode = `RFD_A_DIRECT;
         if (instr[15:12] == 4'h2 && instr[3:2] == 2'h0 &&
            instr[1:0] != 2'h3)
            dst_mode = `RFD_A_IND;
         if (instr[15:12] == 4'h2 && instr[3:2] == 2'h1 &&
            instr[1:0] != 2'h3)
            dst_mode = `RFD_A_PREDEC;
         if (instr[15:12] == 4'h6 && instr[3:2] == 2'h0 &&
            instr[1:0] != 2'h3)
            src_mode = `RFD_A_IND;
         if (instr[15:12] == 4'h6 && instr[3:2] == 2'h1 &&
            instr[1:0] != 2'h3)
            src_mode = `RFD_A_POSTINC;
      end
      4'h4:
      begin
         case (instr[3:0])
            4'h2, 4'h3:
            begin
               fmt = `RFD_F_N;
               src_mode = `RFD_A_CTRLREG;
               dst_mode = `RFD_A_PREDEC;
            end
            4'h6, 4'h7:
            begin
               fmt = `RFD_F_M;
               src_mode = `RFD_A_POSTINC;
               dst_mode = `RFD_A_CTRLREG;
            end
            4'ha, 4'he:
            begin
               fmt = `RFD_F_M;
               src_mode = `RFD_A_DIRECT;
               dst_mode = `RFD_A_CTRLREG;
            end
            4'hb:
            begin
               fmt = `RFD_F_M;
               src_mode = `RFD_A_DIRECT;
            end
            4'hf:
            begin
               fmt = `RFD_F_NM;
               src_mode = `RFD_A_POSTINC;
               dst_mode = `RFD_A_ACCUM;
            end
            default:
            begin
               fmt = `RFD_F_N;
               dst_mode = `RFD_A_DIRECT;
            end
         endcase
      end
      4'h5:
      begin
         fmt = `RFD_F_NMD;
         src_mode = `RFD_A_BASEDISP;
         dst_mode = `RFD_A_DIRECT;
      end
      4'h7, 4'he:
      begin
         fmt = `RFD_F_NI;
         src_mode = `RFD_A_IMM;
         dst_mode = `RFD_A_DIRECT;
         imm_ext = `RFD_X_SIGN;
      end
      4'h8:
      begin
         case (instr[11:8])
            4'h0, 4'h1:
            begin
               fmt = `RFD_F_ND4;
               src_mode = `RFD_A_DIRECT;
               dst_mode = `RFD_A_BASEDISP;
            end
            4'h4, 4'h5:
            begin
               fmt = `RFD_F_MD;
               src_mode = `RFD_A_BASEDISP;
               dst_mode = `RFD_A_DIRECT;
            end
            4'h8:
            begin
               fmt = `RFD_F_I;
               src_mode = `RFD_A_IMM;
               dst_mode = `RFD_A_DIRECT;
               imm_ext = `RFD_X_SIGN;
            end
            default:
            begin
               fmt = `RFD_F_D;
               src_mode = `RFD_A_PCREL;
            end
         endcase
      end
      4'h9, 4'hd:
      begin
         fmt = `RFD_F_ND8;
         src_mode = `RFD_A_PCREL;
         dst_mode = `RFD_A_DIRECT;
      end
      4'ha, 4'hb:
      begin
         fmt = `RFD_F_D12;
         src_mode = `RFD_A_PCREL;
      end
      4'hc:
      begin
         case (instr[11:8])
            4'h0, 4'h1, 4'h2:
            begin
               fmt = `RFD_F_D;
               src_mode = `RFD_A_DIRECT;
               dst_mode = `RFD_A_GBRDISP;
            end
            4'h4, 4'h5, 4'h6:
            begin
               fmt = `RFD_F_D;
               src_mode = `RFD_A_GBRDISP;
               dst_mode = `RFD_A_DIRECT;
            end
            4'h7:
            begin
               fmt = `RFD_F_D;
               src_mode = `RFD_A_PCREL;
               dst_mode = `RFD_A_DIRECT;
            end
            4'h3:
            begin
               fmt = `RFD_F_I;
               src_mode = `RFD_A_IMM;
               imm_ext = `RFD_X_TRAP;
            end
            4'h8, 4'h9, 4'ha, 4'hb:
            begin
               fmt = `RFD_F_I;
               src_mode = `RFD_A_IMM;
               dst_mode = `RFD_A_DIRECT;
               imm_ext = `RFD_X_ZERO;
            end
            default:
            begin
               fmt = `RFD_F_I;
               src_mode = `RFD_A_IMM;
               dst_mode = `RFD_A_GBRINDEX;
               imm_ext = `RFD_X_ZERO;
            end
         endcase
      end
      default:
         fmt = `RFD_F_ZERO;
   endcase
end

endmodule

// >>> rfd_decoder.v
// Top of the 16-bit instruction format decoder: field extraction,
// immediate extension and target/address arithmetic, all registered.
// Assumes fetch and register file sit on ref_clk; register values
// for the word in fetch_instr are presented in the same cycle.
`timescale 1ns/100ps
`include "rfd_defines.vh"
module rfd_decoder
(
   // Clock and reset
   input wire ref_clk,
   input wire arst_n,
   // Fetch side
   input wire fetch_valid,
   input wire [15:0] fetch_instr,
   input wire [31:0] fetch_pc,
   // Register file read values
   input wire [31:0] src_reg_value,
   input wire [31:0] dst_reg_value,
   input wire [31:0] register_zero_value,
   // Decoded word
   output reg dec_valid_q,
   output reg [3:0] dec_format_q,
   output reg [3:0] src_reg_field_q,
   output reg [3:0] dest_reg_field_q,
   output reg [3:0] src_mode_q,
   output reg [3:0] dst_mode_q,
   output reg [11:0] disp_q,
   output reg [31:0] imm_ext_q,
   // Side effects of the operands
   output reg src_post_inc_q,
   output reg dst_pre_dec_q,
   output reg result_to_accum_q,
   // Computed addresses
   output reg [31:0] branch_target_q,
   output reg branch_target_valid_q,
   output reg [31:0] index_addr_q,
   output reg index_addr_valid_q
);

// ****************************************
// Helpers
// ****************************************
// Sign-extend a 12-bit field to the address width
function [31:0] sext12;
   input [11:0] v;
   begin
      sext12 = {{20{v[11]}}, v};
   end
endfunction

// Doubled displacement added to the program counter
function [31:0] pc_plus2x;
   input [31:0] pc;
   input [31:0] d;
   begin
      pc_plus2x = pc + {d[30:0], 1'b0};
   end
endfunction

// ****************************************
// Opcode classification
// ****************************************
wire [3:0] fmt_w;
wire [3:0] src_mode_w;
wire [3:0] dst_mode_w;
wire [1:0] imm_kind_w;

rfd_opmap u_opmap
(
   .instr(fetch_instr),
   .fmt(fmt_w),
   .src_mode(src_mode_w),
   .dst_mode(dst_mode_w),
   .imm_ext(imm_kind_w)
);

// ****************************************
// Field extraction
// ****************************************
reg [3:0] src_idx_d;
reg [3:0] dst_idx_d;
reg [11:0] disp_d;
reg [31:0] imm_d;

// Register indices and offset placed by format
always @*
begin
   src_idx_d = `RFD_RST_IDX;
   dst_idx_d = `RFD_RST_IDX;
   disp_d = 12'h000;
   case (fmt_w)
      `RFD_F_N:
         dst_idx_d = fetch_instr[11:8];
      `RFD_F_M:
         src_idx_d = fetch_instr[11:8];
      `RFD_F_NM:
      begin
         dst_idx_d = fetch_instr[11:8];
         src_idx_d = fetch_instr[7:4];
      end
      `RFD_F_MD:
      begin
         src_idx_d = fetch_instr[7:4];
         disp_d = {8'h00, fetch_instr[3:0]};
      end
      `RFD_F_ND4:
      begin
         dst_idx_d = fetch_instr[7:4];
         disp_d = {8'h00, fetch_instr[3:0]};
      end
      `RFD_F_NMD:
      begin
         dst_idx_d = fetch_instr[11:8];
         src_idx_d = fetch_instr[7:4];
         disp_d = {8'h00, fetch_instr[3:0]};
      end
      `RFD_F_D:
         disp_d = {4'h0, fetch_instr[7:0]};
      `RFD_F_D12:
         disp_d = fetch_instr[11:0];
      `RFD_F_ND8:
      begin
         dst_idx_d = fetch_instr[11:8];
         disp_d = {4'h0, fetch_instr[7:0]};
      end
      `RFD_F_NI:
         dst_idx_d = fetch_instr[11:8];
      default:
         disp_d = 12'h000;
   endcase
   // Fixed register zero wherever the format names no destination
   // field but the operand is a direct register
   if ((fmt_w == `RFD_F_MD || fmt_w == `RFD_F_D || fmt_w == `RFD_F_I)
      && dst_mode_w == `RFD_A_DIRECT)
      dst_idx_d = `RFD_RST_IDX;
   if ((fmt_w == `RFD_F_ND4 || fmt_w == `RFD_F_D)
      && src_mode_w == `RFD_A_DIRECT)
      src_idx_d = `RFD_RST_IDX;
end

// Immediate data, never a register index
always @*
begin
   case (imm_kind_w)
      `RFD_X_SIGN:
         imm_d = {{24{fetch_instr[7]}}, fetch_instr[7:0]};
      `RFD_X_TRAP:
         imm_d = {22'h000000, fetch_instr[7:0], 2'h0};
      default:
         imm_d = {24'h000000, fetch_instr[7:0]};
   endcase
   if (src_mode_w != `RFD_A_IMM)
      imm_d = `RFD_RST_WORD;
end

// ****************************************
// Address arithmetic
// ****************************************
reg [31:0] target_d;
reg target_ok_d;
wire [31:0] index_addr_d;

// Branch targets; a data reference through the pc yields none here
always @*
begin
   target_d = `RFD_RST_WORD;
   target_ok_d = 1'b0;
   if (fmt_w == `RFD_F_D12)
   begin
      target_d = pc_plus2x(fetch_pc, sext12(disp_d));
      target_ok_d = 1'b1;
   end
   else if (fmt_w == `RFD_F_D && src_mode_w == `RFD_A_PCREL &&
      dst_mode_w == `RFD_A_NONE)
   begin
      target_d = pc_plus2x(fetch_pc,
         sext12({{4{disp_d[7]}}, disp_d[7:0]}));
      target_ok_d = 1'b1;
   end
   else if (fmt_w == `RFD_F_M && src_mode_w == `RFD_A_PCREL)
   begin
      target_d = fetch_pc + src_reg_value;
      target_ok_d = 1'b1;
   end
end

// Indexed store address uses register zero plus destination
assign index_addr_d = register_zero_value + dst_reg_value;

// ****************************************
// Output register
// ****************************************
// One cycle of latency; a bubble clears the qualifier flags so no
// stale side effect is seen downstream
always @(posedge ref_clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      dec_valid_q <= 1'b0;
      dec_format_q <= `RFD_F_ZERO;
      src_reg_field_q <= `RFD_RST_IDX;
      dest_reg_field_q <= `RFD_RST_IDX;
      src_mode_q <= `RFD_A_NONE;
      dst_mode_q <= `RFD_A_NONE;
      disp_q <= 12'h000;
      imm_ext_q <= `RFD_RST_WORD;
      src_post_inc_q <= 1'b0;
      dst_pre_dec_q <= 1'b0;
      result_to_accum_q <= 1'b0;
      branch_target_q <= `RFD_RST_WORD;
      branch_target_valid_q <= 1'b0;
      index_addr_q <= `RFD_RST_WORD;
      index_addr_valid_q <= 1'b0;
   end
   else
   begin
      dec_valid_q <= fetch_valid;
      dec_format_q <= fmt_w;
      src_reg_field_q <= src_idx_d;
      dest_reg_field_q <= dst_idx_d;
      src_mode_q <= src_mode_w;
      dst_mode_q <= dst_mode_w;
      disp_q <= disp_d;
      imm_ext_q <= imm_d;
      // Read at the register, then bump it
      src_post_inc_q <= fetch_valid &&
         src_mode_w == `RFD_A_POSTINC;
      dst_pre_dec_q <= fetch_valid && dst_mode_w == `RFD_A_PREDEC;
      result_to_accum_q <= fetch_valid &&
         dst_mode_w == `RFD_A_ACCUM;
      branch_target_q <= target_d;
      branch_target_valid_q <= fetch_valid && target_ok_d;
      index_addr_q <= index_addr_d;
      index_addr_valid_q <= fetch_valid &&
         dst_mode_w == `RFD_A_INDEXED;
   end
end

endmodule

// >>> rfd_regfile_model.sv
// Register file stand-in on the read side of the instruction decoder.
// Assumes the bench supplies a base value; each register is derived
// from it, and values follow fetch_instr in the same cycle.
`timescale 1ns/100ps
module rfd_regfile_model
(
   // Fetch side
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_instr,
   input wire logic [31:0] base,
   // Read values
   output logic [31:0] src_reg_value,
   output logic [31:0] dst_reg_value,
   output logic [31:0] register_zero_value
);
   logic [3:0] src_idx;
   logic far_word;

   // Far branch names its source in 11..8, all others in 7..4
   always_comb
   begin
      far_word = fetch_instr[15:12] == 4'h0 && fetch_instr[3:0] == 4'h3;
      src_idx = far_word ? fetch_instr[11:8] : fetch_instr[7:4];
      src_reg_value = base ^ {8{src_idx}};
      dst_reg_value = base ^ {8{fetch_instr[11:8]}};
      register_zero_value = base;
      // No word in flight: show inverted data so stale values never match
      if (!fetch_valid)
      begin
         src_reg_value = ~src_reg_value;
         dst_reg_value = ~dst_reg_value;
         register_zero_value = ~base;
      end
   end
endmodule

// >>> rfd_decoder_sva.sv
// Concurrent checks on the decoder's ports, one cycle from fetch to result.
// Assumes a single ref_clk domain with asynchronous active-low arst_n.
`timescale 1ns/100ps
`include "rfd_defines.vh"
module rfd_decoder_chk
(
   // Clock and reset
   input wire ref_clk,
   input wire arst_n,
   // Fetch side and register values
   input wire fetch_valid,
   input wire [15:0] fetch_instr,
   input wire [31:0] fetch_pc,
   input wire [31:0] dst_reg_value,
   input wire [31:0] register_zero_value,
   // Decoded word
   input wire dec_valid_q,
   input wire [3:0] dec_format_q,
   input wire [3:0] src_reg_field_q,
   input wire [3:0] dest_reg_field_q,
   input wire [3:0] src_mode_q,
   input wire [11:0] disp_q,
   input wire [31:0] imm_ext_q,
   input wire src_post_inc_q,
   input wire result_to_accum_q,
   input wire [31:0] branch_target_q,
   input wire branch_target_valid_q,
   input wire [31:0] index_addr_q,
   input wire index_addr_valid_q
);
   // ****************************************
   // Sequences
   // ****************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   // A valid word whose masked bits equal a pattern
   sequence s_word(logic [15:0] mask, logic [15:0] val);
      fetch_valid && ((fetch_instr & mask) == val);
   endsequence
   // Last word of a burst followed by an idle cycle
   sequence s_last;
      fetch_valid ##1 !fetch_valid;
   endsequence

   // ****************************************
   // Assertions
   // ****************************************
   AST_NM_FIELDS: assert property (s_word(16'hf00f, 16'h300c) |=>
      dec_format_q == `RFD_F_NM && dest_reg_field_q == $past(fetch_instr[11:8])
      && src_reg_field_q == $past(fetch_instr[7:4]))
      else $error("two-register fields wrong");
   AST_MD_FIELDS: assert property (s_word(16'hff00, 16'h8400) |=>
      src_reg_field_q == $past(fetch_instr[7:4]) && dest_reg_field_q == 4'h0
      && disp_q == {8'h00, $past(fetch_instr[3:0])})
      else $error("displacement load fields wrong");
   AST_ND4_FIELDS: assert property (s_word(16'hff00, 16'h8000) |=>
      dest_reg_field_q == $past(fetch_instr[7:4]) && src_reg_field_q == 4'h0)
      else $error("displacement store fields wrong");
   AST_JUMP_TARGET: assert property (s_word(16'hf000, 16'ha000) |=>
      branch_target_valid_q && branch_target_q == $past(fetch_pc) +
      {{19{$past(fetch_instr[11])}}, $past(fetch_instr[11:0]), 1'b0})
      else $error("relative jump target wrong");
   AST_LOGIC_ZEXT: assert property (s_word(16'hfc00, 16'hc800) |=>
      imm_ext_q == {24'h000000, $past(fetch_instr[7:0])})
      else $error("logical immediate not zero-extended");
   AST_MOVE_SEXT: assert property (s_word(16'hf000, 16'he000) |=>
      imm_ext_q == {{24{$past(fetch_instr[7])}}, $past(fetch_instr[7:0])})
      else $error("move immediate not sign-extended");
   AST_TRAP_QUAD: assert property (s_word(16'hff00, 16'hc300) |=>
      imm_ext_q == {22'h000000, $past(fetch_instr[7:0]), 2'h0})
      else $error("trap immediate wrong");
   AST_MAC_ACCUM: assert property (s_word(16'hf00f, 16'h000f) |=>
      result_to_accum_q && src_post_inc_q && src_mode_q == `RFD_A_POSTINC)
      else $error("multiply-accumulate operands wrong");
   AST_INDEX_SUM: assert property (index_addr_valid_q |->
      index_addr_q == $past(register_zero_value) + $past(dst_reg_value))
      else $error("indexed address wrong");
   AST_IDLE_DROP: assert property (s_last |=> !dec_valid_q &&
      !branch_target_valid_q && !index_addr_valid_q)
      else $error("flags stay up without a word");
endmodule

bind rfd_decoder rfd_decoder_chk u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
   .fetch_valid(fetch_valid), .fetch_instr(fetch_instr),
   .fetch_pc(fetch_pc), .dst_reg_value(dst_reg_value),
   .register_zero_value(register_zero_value), .dec_valid_q(dec_valid_q),
   .dec_format_q(dec_format_q), .src_reg_field_q(src_reg_field_q),
   .dest_reg_field_q(dest_reg_field_q), .src_mode_q(src_mode_q),
   .disp_q(disp_q), .imm_ext_q(imm_ext_q), .src_post_inc_q(src_post_inc_q),
   .result_to_accum_q(result_to_accum_q), .branch_target_q(branch_target_q),
   .branch_target_valid_q(branch_target_valid_q),
   .index_addr_q(index_addr_q), .index_addr_valid_q(index_addr_valid_q));

// >>> rfd_decoder_tb.sv
// Self-checking bench: drives words with a random idle cycle after about one in four, queues expectations.
// Assumes rfd_regfile_model answers register reads in the same cycle.
`timescale 1ns/100ps
`include "rfd_defines.vh"
module rfd_decoder_tb;
   typedef struct packed {
      logic [3:0] f, s, d, sm, dm;
      logic [2:0] fl;
      logic dk, tv, iv;
      logic [11:0] dp;
      logic [31:0] imm, tgt, ia;
   } rfd_exp_t;
   localparam [3:0] a_dr = `RFD_A_DIRECT, a_pi = `RFD_A_POSTINC;
   localparam [3:0] a_pd = `RFD_A_PREDEC, a_ix = `RFD_A_INDEXED;
   localparam [3:0] a_bd = `RFD_A_BASEDISP, a_pr = `RFD_A_PCREL;
   localparam [3:0] a_im = `RFD_A_IMM, a_no = `RFD_A_NONE, a_x = 4'hf;
   logic ref_clk, arst_n, fetch_valid;
   logic [15:0] fetch_instr, r;
   logic [31:0] fetch_pc, base;
   logic [3:0] n, m;
   logic [7:0] b;
   wire [31:0] src_reg_value, dst_reg_value, register_zero_value;
   wire dec_valid_q, src_post_inc_q, dst_pre_dec_q, result_to_accum_q;
   wire branch_target_valid_q, index_addr_valid_q;
   wire [3:0] dec_format_q, src_reg_field_q, dest_reg_field_q;
   wire [3:0] src_mode_q, dst_mode_q;
   wire [11:0] disp_q;
   wire [31:0] imm_ext_q, branch_target_q, index_addr_q;
   rfd_exp_t expq[$];
   rfd_exp_t ex;
   integer seed, errors, compares, k, t;

   // ****************************************
   // Clock, design and register file
   // ****************************************
   always #12.5 ref_clk = ~ref_clk;

   rfd_decoder uut
   (
      .ref_clk(ref_clk), .arst_n(arst_n), .fetch_valid(fetch_valid),
      .fetch_instr(fetch_instr), .fetch_pc(fetch_pc),
      .src_reg_value(src_reg_value), .dst_reg_value(dst_reg_value),
      .register_zero_value(register_zero_value), .dec_valid_q(dec_valid_q),
      .dec_format_q(dec_format_q), .src_reg_field_q(src_reg_field_q),
      .dest_reg_field_q(dest_reg_field_q), .src_mode_q(src_mode_q),
      .dst_mode_q(dst_mode_q), .disp_q(disp_q), .imm_ext_q(imm_ext_q),
      .src_post_inc_q(src_post_inc_q), .dst_pre_dec_q(dst_pre_dec_q),
      .result_to_accum_q(result_to_accum_q),
      .branch_target_q(branch_target_q),
      .branch_target_valid_q(branch_target_valid_q),
      .index_addr_q(index_addr_q), .index_addr_valid_q(index_addr_valid_q)
   );

   rfd_regfile_model u_regs
   (
      .fetch_valid(fetch_valid), .fetch_instr(fetch_instr), .base(base),
      .src_reg_value(src_reg_value), .dst_reg_value(dst_reg_value),
      .register_zero_value(register_zero_value)
   );

   // ****************************************
   // Helpers
   // ****************************************
   // Register contents as the bench expects them
   function logic [31:0] rv(input logic [3:0] i);
      rv = base ^ {8{i}};
   endfunction

   task cmp(input string nm, input logic [31:0] x, input logic [31:0] y);
      begin
         compares = compares + 1;
         if (x !== y)
         begin
            errors = errors + 1;
            $display("MISMATCH %s expected %h seen %h", nm, x, y);
         end
      end
   endtask

   task conclude;
      begin
         $display("compares %0d errors %0d", compares, errors);
         if (errors == 0 && compares > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask

   // Queue the expectation, then present the word; idle now and then
   task drv(input logic [15:0] w, input logic [3:0] f, s, d, sm, dm,
            input int fl, xk, tk);
      rfd_exp_t e;
      logic [31:0] pc;
      begin
         pc = $random(seed) & 32'h7fff_fffe;
         e = '0;
         e.f = f;
         e.s = s;
         e.d = d;
         e.sm = sm;
         e.dm = dm;
         e.fl = fl[2:0];
         e.imm = xk == 1 ? {24'h0, w[7:0]} : xk == 2 ?
            {{24{w[7]}}, w[7:0]} : xk == 3 ? {22'h0, w[7:0], 2'h0} : 32'h0;
         e.tv = tk == 1 || tk == 2 || tk == 3;
         e.tgt = tk == 1 ? pc + {{19{w[11]}}, w[11:0], 1'b0} : tk == 2 ?
            pc + {{23{w[7]}}, w[7:0], 1'b0} : pc + rv(s);
         e.iv = tk == 4;
         e.ia = rv(4'h0) + rv(d);
         e.dk = f == `RFD_F_D12 || f == `RFD_F_D || f == `RFD_F_ND8 ||
            f == `RFD_F_MD || f == `RFD_F_ND4 || f == `RFD_F_NMD;
         e.dp = f == `RFD_F_D12 ? w[11:0] : (f == `RFD_F_D ||
            f == `RFD_F_ND8) ? {4'h0, w[7:0]} : {8'h0, w[3:0]};
         expq.push_back(e);
         @(negedge ref_clk);
         fetch_valid = 1'b1;
         fetch_instr = w;
         fetch_pc = pc;
         if (($random(seed) & 3) == 0)
         begin
            @(negedge ref_clk);
            fetch_valid = 1'b0;
            fetch_instr = ~w;
         end
      end
   endtask

   // One pass over every format except N, with fresh random fields
   task run_all;
      begin
         r = 16'($random(seed));
         n = r[11:8];
         m = r[7:4];
         b = r[7:0];
         drv({4'h3, n, m, 4'hc}, `RFD_F_NM, m, n, a_dr, a_dr, 0, 0, 0);
         drv({4'h0, n, m, 4'hf}, `RFD_F_NM, m, n, a_pi, a_x, 5, 0, 0);
         drv({4'h6, n, m, 4'h6}, `RFD_F_NM, m, n, a_pi, a_dr, 4, 0, 0);
         drv({4'h2, n, m, 4'h6}, `RFD_F_NM, m, n, a_dr, a_pd, 2, 0, 0);
         drv({4'h0, n, m, 4'h6}, `RFD_F_NM, m, n, a_dr, a_ix, 0, 0, 4);
         drv({4'h4, n, 8'h07}, `RFD_F_M, n, 4'h0, a_pi, a_x, 4, 0, 0);
         drv({4'h0, n, 8'h23}, `RFD_F_M, n, 4'h0, a_pr, a_x, 0, 0, 3);
         drv({8'h84, b}, `RFD_F_MD, m, 4'h0, a_bd, a_dr, 0, 0, 0);
         drv({8'h80, b}, `RFD_F_ND4, 4'h0, m, a_dr, a_bd, 0, 0, 0);
         drv({4'h1, r[11:0]}, `RFD_F_NMD, m, n, a_dr, a_bd, 0, 0, 0);
         drv({4'h5, r[11:0]}, `RFD_F_NMD, m, n, a_bd, a_dr, 0, 0, 0);
         drv({8'h8b, b}, `RFD_F_D, 4'h0, 4'h0, a_pr, a_x, 0, 0, 2);
         drv({6'h31, r[13:12], b}, `RFD_F_D, 4'h0, 4'h0,
            &r[13:12] ? a_pr : `RFD_A_GBRDISP, a_dr, 0, 0, 0);
         drv({4'ha, r[11:0]}, `RFD_F_D12, 4'h0, 4'h0, a_pr, a_x, 0, 0, 1);
         drv({4'hd, n, b}, `RFD_F_ND8, 4'h0, n, a_pr, a_dr, 0, 0, 0);
         drv({4'he, n, b}, `RFD_F_NI, 4'h0, n, a_im, a_dr, 0, 2, 0);
         drv({4'h7, n, b}, `RFD_F_NI, 4'h0, n, a_im, a_dr, 0, 2, 0);
         drv({8'h88, b}, `RFD_F_I, 4'h0, 4'h0, a_im, a_x, 0, 2, 0);
         for (t = 0; t < 8; t = t + 1)
            drv({5'h19, t[2:0], b}, `RFD_F_I, 4'h0, 4'h0, a_im,
               t[2] ? `RFD_A_GBRINDEX : a_dr, 0, 1, 0);
         drv({8'hc3, b}, `RFD_F_I, 4'h0, 4'h0, a_im, a_x, 0, 3, 0);
         drv(16'hffff, `RFD_F_ZERO, 4'h0, 4'h0, a_no, a_no, 0, 0, 0);
      end
   endtask

   // ****************************************
   // Result watcher
   // ****************************************
   always @(posedge ref_clk)
   begin
      #1;
      if (dec_valid_q === 1'b1 && expq.size() == 0)
         cmp("unexpected word", 32'h0, 32'h1);
      else if (dec_valid_q === 1'b1)
      begin
         ex = expq.pop_front();
         cmp("format", ex.f, dec_format_q);
         cmp("source index", ex.s, src_reg_field_q);
         cmp("dest index", ex.d, dest_reg_field_q);
         if (ex.sm != a_x)
            cmp("source mode", ex.sm, src_mode_q);
         if (ex.dm != a_x)
            cmp("dest mode", ex.dm, dst_mode_q);
         cmp("side flags", ex.fl,
            {src_post_inc_q, dst_pre_dec_q, result_to_accum_q});
         cmp("immediate", ex.imm, imm_ext_q);
         if (ex.dk)
            cmp("displacement", ex.dp, disp_q);
         cmp("target valid", ex.tv, branch_target_valid_q);
         if (ex.tv)
            cmp("target", ex.tgt, branch_target_q);
         cmp("index valid", ex.iv, index_addr_valid_q);
         if (ex.iv)
            cmp("index address", ex.ia, index_addr_q);
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      seed = 93;
      errors = 0;
      compares = 0;
      ref_clk = 1'b0;
      arst_n = 1'b0;
      fetch_valid = 1'b0;
      fetch_instr = 16'h0000;
      fetch_pc = 32'h0000_0000;
      base = $random(seed);
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      arst_n = 1'b1;
      for (k = 0; k < 40; k = k + 1)
         run_all();
      // Reset once the stream has drained: outputs must clear at once
      @(negedge ref_clk);
      fetch_valid = 1'b0;
      for (t = 0; t < 10 && expq.size() != 0; t = t + 1)
         @(negedge ref_clk);
      if (expq.size() != 0)
         cmp("results drained", 32'h0, expq.size());
      arst_n = 1'b0;
      #2;
      cmp("valid in reset", 32'h0, dec_valid_q);
      cmp("target in reset", 32'h0, branch_target_q);
      @(negedge ref_clk);
      arst_n = 1'b1;
      run_all();
      for (t = 0; t < 10 && expq.size() != 0; t = t + 1)
         @(negedge ref_clk);
      if (expq.size() != 0)
         cmp("results drained", 32'h0, expq.size());
      conclude();
   end
endmodule
